// ==== wem_consts.svh ====
// Constants of the waveform edge timing measurement engine.
// Included by the package and the engine; holds definitions only.
`ifndef WEM_CONSTS_SVH
`define WEM_CONSTS_SVH
`define WEM_SW 8
`define WEM_IW 16
`define WEM_F 4
`define WEM_TW 20
`define WEM_MIN_PTS 3
`define WEM_FREQ_NUM 32'h8000_0000
`define WEM_PCT 32'h0000_0064
`define WEM_NV 13
`define WEM_V_RISE 0
`define WEM_V_FALL 1
`define WEM_V_PER 2
`define WEM_V_FREQ 3
`define WEM_V_PW 4
`define WEM_V_NW 5
`define WEM_V_DUTY 6
`define WEM_V_DELTA 7
`define WEM_V_CYC 8
`define WEM_V_OVER 9
`define WEM_V_PRE 10
`define WEM_V_AVG 11
`define WEM_V_RMS 12
`endif

// ==== wem_pkg.sv ====
// Types shared by the measurement engine and its users.
// Assumes wem_consts.svh is on the include path.
`include "wem_consts.svh"
package wem_pkg;
  typedef logic signed [`WEM_SW-1:0] wem_smp_t;
  typedef logic [`WEM_TW-1:0] wem_tm_t;
  typedef struct packed {wem_smp_t lower, mid, upper, top, base;} wem_lvl_t;
  typedef struct packed {logic [1:0] lvl; logic fall; logic [7:0] num;} wem_dsel_t;
  typedef struct packed {
    wem_tm_t rise, fall, period, pwidth, nwidth, delta;
    logic [31:0] freq;
    logic [6:0] duty;
    wem_smp_t vmin, vmax, vtop, vbase, avg, cyc_avg;
    logic [`WEM_SW:0] vpp, amp, over, pre;
    logic [`WEM_SW-1:0] dc_rms, ac_rms;
    logic rise_q, fall_q;
    logic [`WEM_NV-1:0] vld;
  } wem_res_t;
  typedef struct packed {
    logic fl, con, ms;
    wem_tm_t cl, cm, e1l, e1u, e1m, e2m;
    logic [`WEM_IW-1:0] cs, e1s, e1e;
    logic [7:0] n;
    wem_tm_t [1:0] dt;
    logic [1:0] dk;
  } wem_trk_t;
  typedef struct packed {
    logic [`WEM_IW-1:0] idx;
    logic signed [`WEM_SW:0] prv;
    logic hp, fp, fe, pv, ov;
    wem_smp_t vmin, vmax, pmin, pmax, omin, omax;
    logic signed [31:0] sum, csum;
    logic [31:0] sq, cnt, ccnt;
  } wem_acc_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_P1 = 3'b001, ST_TIME = 3'b010, ST_P2 = 3'b011, ST_VOLT = 3'b100
  } wem_st_t;
endpackage

// ==== wem_measure.sv ====
// Edge finding and pulse measurement engine over a streamed sample record.
// Assumes the record source replays the whole record while RECORD_REQ_O is high.
//
// How it works
// R01: Rising edge needs lower, middle, upper in order.
// R02: Falling edge needs upper, middle, lower in order.
// R03: Incomplete transitions and glitches are never listed.
// R04: Lower and upper crossings interpolated between samples.
// R05: Timing results first, cycle voltages afterwards.
// R06: Too few edge samples marks result questionable.
// R07: Rising span: before lower to past upper.
// R08: Falling span: before upper to past lower.
// R09: Middle crossing sits midway between samples.
// R10: Report min, max and their difference.
// R11: Report given top, base and their difference.
// R12: First-cycle average, average, DC and AC RMS.
// R13: Overshoot depends on first edge polarity.
// R14: Preshoot depends on first edge polarity.
// R15: Preshoot before edge; overshoot first half.
// R16: Timing taken from first edges found.
// R17: Rise and fall from upper/lower crossings.
// R18: Period between like edges; frequency reciprocal.
// R19: Positive width and duty cycle by polarity.
// R20: Negative width by first edge polarity.
// R21: Delta time between two selected edges.
// R22: Other party supplies 10/50/90 percent thresholds.
// R23: Each result carries a valid flag; min, max, peak-to-peak, top, base and amplitude have none.
`timescale 1ns/1ps
`include "wem_consts.svh"
module wem_measure #(
  parameter int MIN_PTS = `WEM_MIN_PTS
) (
  // Clock and reset.
  input  wire logic               CLK_I,
  input  wire logic               RESET_N_I,
  // Control.
  input  wire logic               START_I,
  output logic                    BUSY_O,
  output logic                    DONE_O,
  output logic                    RECORD_REQ_O,
  // Sample stream.
  input  wire logic               SMP_VALID_I,
  input  wire logic               SMP_LAST_I,
  input  wire wem_pkg::wem_smp_t  SMP_DATA_I,
  // Levels and delta selection.
  input  wire wem_pkg::wem_lvl_t  LVL_I,
  input  wire wem_pkg::wem_dsel_t DSEL_A_I,
  input  wire wem_pkg::wem_dsel_t DSEL_B_I,
  // Results.
  output wem_pkg::wem_res_t       RES_O
);
  import wem_pkg::*;
  localparam int SW = `WEM_SW;
  localparam int IW = `WEM_IW;
  localparam int F  = `WEM_F;

  // Unsigned restoring division; a zero divisor yields zero.
  function automatic logic [31:0] udiv(input logic [31:0] n, input logic [31:0] d);
    logic [31:0] q;
    logic [32:0] r;
    q = '0;
    r = '0;
    for (int i = 31; i >= 0; i--) begin
      r = {r[31:0], n[i]};
      if (d != '0 && r >= {1'b0, d}) begin
        r = r - {1'b0, d};
        q[i] = 1'b1;
      end
    end
    return q;
  endfunction

  // Signed dividend, unsigned divisor, truncating toward zero.
  function automatic logic signed [31:0] sdiv(input logic signed [31:0] n, input logic [31:0] d);
    return n[31] ? -$signed(udiv(-n, d)) : $signed(udiv(n, d));
  endfunction

  // Integer square root by bitwise trial.
  function automatic logic [15:0] isqrt(input logic [31:0] v);
    logic [15:0] s;
    logic [15:0] t;
    s = '0;
    for (int i = 15; i >= 0; i--) begin
      t = s | (16'h0001 << i);
      if (32'(t) * 32'(t) <= v) s = t;
    end
    return s;
  endfunction

  // Sign extension of a sample by one bit, so negation cannot overflow.
  function automatic logic signed [SW:0] x1(input wem_smp_t v);
    return {v[SW-1], v};
  endfunction

  // Crossing position of level t between samples idx-1 (a) and idx (b).
  function automatic wem_tm_t xpos(input logic [IW-1:0] idx, input logic signed [SW:0] a,
                                   input logic signed [SW:0] b, input logic signed [SW:0] t);
    logic [31:0] num;
    logic [31:0] den;
    logic [31:0] q;
    num = 32'(t > a ? t - a : a - t);
    den = 32'(b > a ? b - a : a - b);
    q = udiv(num << F, den);
    return {idx - 1'b1, q[F-1:0]};
  endfunction

  wem_st_t             st;
  wem_st_t             next_st;
  wem_acc_t            a;
  wem_acc_t            next_a;
  wem_trk_t [1:0]      tr;
  wem_trk_t [1:0]      next_tr;
  wem_res_t            next_res;
  wem_dsel_t [1:0]     dsel;
  logic [1:0]          ev;
  logic                p1;
  logic                p2;
  logic                clr;
  logic signed [SW:0]  cur;

  assign dsel = {DSEL_B_I, DSEL_A_I};
  assign p1   = (st == ST_P1) && SMP_VALID_I;
  assign p2   = (st == ST_P2) && SMP_VALID_I;
  assign clr  = (st == ST_IDLE) && START_I;
  assign cur  = x1(SMP_DATA_I);

  // One tracker per polarity; the falling one sees the mirrored record, so one copy serves both.
  for (genvar g = 0; g < 2; g++) begin : g_trk
    logic signed [SW:0] s, ps, lo, md, hi;
    logic               ul, um, uu;
    wem_tm_t            lt, mt, ut;
    logic [IW-1:0]      sp;
    always_comb begin
      s  = g ? -cur : cur;
      ps = g ? -a.prv : a.prv;
      lo = g ? -x1(LVL_I.upper) : x1(LVL_I.lower);
      md = g ? -x1(LVL_I.mid) : x1(LVL_I.mid);
      hi = g ? -x1(LVL_I.lower) : x1(LVL_I.upper);
      ul = a.hp && ps < lo && s >= lo;
      um = a.hp && ps < md && s >= md;
      uu = a.hp && ps < hi && s >= hi;
      lt = ul ? xpos(a.idx, ps, s, lo) : tr[g].cl; // R04
      ut = xpos(a.idx, ps, s, hi); // R04
      mt = um ? {a.idx - 1'b1, 1'b1, {(F-1){1'b0}}} : tr[g].cm; // R09
      sp = ul ? a.idx - 1'b1 : tr[g].cs; // R07 R08
      ev[g] = p1 && tr[g].fl && (tr[g].con || ul) && uu && (tr[g].ms || um); // R01 R02
      next_tr[g] = tr[g];
      if (clr) begin
        next_tr[g] = '0;
      end else if (p1) begin
        next_tr[g].con = tr[g].con || ul;
        next_tr[g].ms  = tr[g].ms || um;
        next_tr[g].cl  = lt;
        next_tr[g].cm  = mt;
        next_tr[g].cs  = sp;
        if (s < lo) begin
          next_tr[g].fl  = 1'b1; // R03
          next_tr[g].con = 1'b0;
          next_tr[g].ms  = 1'b0;
        end
        if (ev[g]) begin
          next_tr[g].fl  = 1'b0;
          next_tr[g].con = 1'b0;
          next_tr[g].ms  = 1'b0;
          if (tr[g].n != 8'hff) next_tr[g].n = tr[g].n + 8'h01;
          if (tr[g].n == 8'h00) begin
            next_tr[g].e1l = lt; // R17
            next_tr[g].e1u = ut;
            next_tr[g].e1m = mt;
            next_tr[g].e1s = sp; // R07 R08
            next_tr[g].e1e = a.idx;
          end
          if (tr[g].n == 8'h01) next_tr[g].e2m = mt; // R18
          for (int k = 0; k < 2; k++) begin
            if (dsel[k].fall == (g == 1) && dsel[k].num == tr[g].n + 8'h01) begin
              next_tr[g].dk[k] = 1'b1; // R21
              if (dsel[k].lvl == 2'h0) next_tr[g].dt[k] = g ? ut : lt;
              else if (dsel[k].lvl == 2'h2) next_tr[g].dt[k] = g ? lt : ut;
              else next_tr[g].dt[k] = mt;
            end
          end
        end
      end
    end

    // Tracker registers.
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) tr[g] <= '0;
      else tr[g] <= next_tr[g];
    end

    chk_edge_count: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R01 R02
      ev[g] && tr[g].n != 8'hff |=> tr[g].n == $past(tr[g].n) + 8'h01)
      else $error("edge count did not advance");
    chk_glitch_drop: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R03
      p1 && !ev[g] && s < lo |=> !tr[g].con && !tr[g].ms && tr[g].fl)
      else $error("glitch candidate survived");
    chk_mid_half: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R09
      ev[g] && tr[g].n == 8'h00 |=> tr[g].e1m[F-1:0] == {1'b1, {(F-1){1'b0}}})
      else $error("middle crossing not at midpoint");
  end

  // Sequencing: edge pass, timing, cycle pass, voltages.
  always_comb begin
    next_st = st;
    case (st)
      ST_IDLE: if (START_I) next_st = ST_P1;
      ST_P1:   if (SMP_VALID_I && SMP_LAST_I) next_st = ST_TIME;
      ST_TIME: next_st = ST_P2; // R05
      ST_P2:   if (SMP_VALID_I && SMP_LAST_I) next_st = ST_VOLT;
      ST_VOLT: next_st = ST_IDLE;
      default: next_st = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) st <= ST_IDLE;
    else st <= next_st;
  end

  // Accumulators for both passes; window limits come from the edges of the first pass.
  logic          fp;
  wem_tm_t       pos, ohalf;
  logic          in_pre, in_ovr, in_cyc;
  always_comb begin
    fp     = a.fp;
    pos    = {a.idx, {F{1'b0}}};
    ohalf  = (tr[!fp].e1m - tr[fp].e1m) >> 1;
    in_pre = a.fe && a.idx < tr[fp].e1s; // R15
    in_ovr = a.fe && a.idx >= tr[fp].e1e && (tr[!fp].n == 8'h00 || pos <= tr[fp].e1m + ohalf); // R15
    in_cyc = tr[fp].n >= 8'h02 && pos >= tr[fp].e1m && pos < tr[fp].e2m; // R12
    next_a = a;
    if (clr || st == ST_TIME) begin
      next_a.idx = '0;
      next_a.hp  = 1'b0;
      if (clr) next_a = '0;
    end else if (p1 || p2) begin
      next_a.idx = a.idx + 1'b1;
      next_a.prv = cur;
      next_a.hp  = 1'b1;
    end
    if (p1) begin
      if (!a.hp || SMP_DATA_I < a.vmin) next_a.vmin = SMP_DATA_I; // R10
      if (!a.hp || SMP_DATA_I > a.vmax) next_a.vmax = SMP_DATA_I;
      next_a.sum = a.sum + 32'(cur);
      next_a.sq  = a.sq + 32'(cur * cur);
      next_a.cnt = a.cnt + 32'h1;
      if (!a.fe && ev != 2'b00) begin
        next_a.fe = 1'b1; // R16
        next_a.fp = ev[1];
      end
    end
    if (p2) begin
      if (in_pre && (!a.pv || SMP_DATA_I < a.pmin)) next_a.pmin = SMP_DATA_I;
      if (in_pre && (!a.pv || SMP_DATA_I > a.pmax)) next_a.pmax = SMP_DATA_I;
      if (in_ovr && (!a.ov || SMP_DATA_I < a.omin)) next_a.omin = SMP_DATA_I;
      if (in_ovr && (!a.ov || SMP_DATA_I > a.omax)) next_a.omax = SMP_DATA_I;
      next_a.pv = a.pv || in_pre;
      next_a.ov = a.ov || in_ovr;
      if (in_cyc) begin
        next_a.csum = a.csum + 32'(cur);
        next_a.ccnt = a.ccnt + 32'h1;
      end
    end
  end

  // Accumulator registers.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) a <= '0;
    else a <= next_a;
  end

  // Result computation: timing in one state, voltages in a later one.
  logic signed [31:0] av;
  logic [31:0]        msq, avsq, per32, pw32;
  always_comb begin
    next_res = RES_O;
    av    = sdiv(a.sum, a.cnt);
    msq   = udiv(a.sq, a.cnt);
    avsq  = 32'(av * av);
    per32 = 32'(tr[fp].e2m - tr[fp].e1m);
    pw32  = 32'(fp ? tr[1].e2m - tr[0].e1m : tr[1].e1m - tr[0].e1m);
    if (st == ST_TIME) begin
      next_res.rise   = tr[0].e1u - tr[0].e1l; // R17
      next_res.fall   = tr[1].e1u - tr[1].e1l;
      next_res.rise_q = 32'(tr[0].e1e - tr[0].e1s) + 32'h1 < 32'(MIN_PTS); // R06
      next_res.fall_q = 32'(tr[1].e1e - tr[1].e1s) + 32'h1 < 32'(MIN_PTS);
      next_res.period = per32[`WEM_TW-1:0]; // R18
      next_res.freq   = udiv(`WEM_FREQ_NUM, per32);
      next_res.pwidth = pw32[`WEM_TW-1:0]; // R19
      next_res.nwidth = fp ? tr[0].e1m - tr[1].e1m : tr[0].e2m - tr[1].e1m; // R20
      next_res.duty   = 7'(udiv(pw32 * `WEM_PCT, per32));
      next_res.delta  = tr[dsel[1].fall].dt[1] - tr[dsel[0].fall].dt[0]; // R21
      next_res.vld[`WEM_V_RISE]  = tr[0].n != 8'h00; // R23
      next_res.vld[`WEM_V_FALL]  = tr[1].n != 8'h00;
      next_res.vld[`WEM_V_PER]   = tr[fp].n >= 8'h02;
      next_res.vld[`WEM_V_FREQ]  = tr[fp].n >= 8'h02;
      next_res.vld[`WEM_V_PW]    = fp ? tr[1].n >= 8'h02 && tr[0].n != 8'h00 : tr[1].n != 8'h00;
      next_res.vld[`WEM_V_NW]    = fp ? tr[0].n != 8'h00 : tr[0].n >= 8'h02;
      next_res.vld[`WEM_V_DUTY]  = next_res.vld[`WEM_V_PW] && next_res.vld[`WEM_V_PER];
      next_res.vld[`WEM_V_DELTA] = tr[dsel[0].fall].dk[0] && tr[dsel[1].fall].dk[1];
    end
    if (st == ST_VOLT) begin
      next_res.vmin    = a.vmin; // R10
      next_res.vmax    = a.vmax;
      next_res.vpp     = x1(a.vmax) - x1(a.vmin);
      next_res.vtop    = LVL_I.top; // R11
      next_res.vbase   = LVL_I.base;
      next_res.amp     = x1(LVL_I.top) - x1(LVL_I.base);
      next_res.avg     = av[SW-1:0]; // R12
      next_res.cyc_avg = SW'(sdiv(a.csum, a.ccnt));
      next_res.dc_rms  = SW'(isqrt(msq));
      next_res.ac_rms  = SW'(isqrt(avsq > msq ? 32'h0 : msq - avsq));
      next_res.over    = fp ? x1(LVL_I.base) - x1(a.omin) : x1(a.omax) - x1(LVL_I.top); // R13
      next_res.pre     = fp ? x1(LVL_I.base) - x1(a.pmin) : x1(a.pmax) - x1(LVL_I.top); // R14
      next_res.vld[`WEM_V_CYC]  = a.ccnt != 32'h0; // R23
      next_res.vld[`WEM_V_OVER] = a.ov;
      next_res.vld[`WEM_V_PRE]  = a.pv;
      next_res.vld[`WEM_V_AVG]  = a.cnt != 32'h0;
      next_res.vld[`WEM_V_RMS]  = a.cnt != 32'h0;
    end
  end

  // Output registers; every output comes from a flop.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      RES_O        <= '0;
      BUSY_O       <= 1'b0;
      DONE_O       <= 1'b0;
      RECORD_REQ_O <= 1'b0;
    end else begin
      RES_O        <= next_res;
      BUSY_O       <= next_st != ST_IDLE;
      DONE_O       <= st == ST_VOLT;
      RECORD_REQ_O <= next_st == ST_P1 || next_st == ST_P2;
    end
  end

  sequence s_edge_pass_end;
    st == ST_P1 && SMP_VALID_I && SMP_LAST_I;
  endsequence
  sequence s_timing_then_cycle;
    st == ST_TIME ##1 st == ST_P2;
  endsequence
  chk_time_first: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R05
    s_edge_pass_end |=> s_timing_then_cycle)
    else $error("timing not computed before cycle pass");
  chk_pp_diff: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R10
    DONE_O |-> $signed(RES_O.vpp) == x1(RES_O.vmax) - x1(RES_O.vmin))
    else $error("peak to peak mismatch");
  chk_amp_diff: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R11
    DONE_O |-> $signed(RES_O.amp) == x1(RES_O.vtop) - x1(RES_O.vbase))
    else $error("amplitude mismatch");
  chk_per_valid: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R18 R23
    st == ST_TIME |=> RES_O.vld[`WEM_V_PER] == (tr[a.fp].n >= 8'h02))
    else $error("period valid flag wrong");
  chk_rise_q: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // R06
    st == ST_TIME && tr[0].n != 8'h00 && 32'(tr[0].e1e - tr[0].e1s) + 32'h1 < 32'(MIN_PTS) |=> RES_O.rise_q)
    else $error("short edge not questionable");
  chk_done_pulse: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
    DONE_O |-> !BUSY_O ##1 !DONE_O)
    else $error("done not a single pulse");
endmodule

// ==== wem_rec_src.sv ====
// Behavioural acquisition memory that replays one stored record per request.
// Assumes the engine takes a sample at each rising edge with valid and request both high.
`timescale 1ns/1ps
module wem_rec_src (
  // Clock.
  input  wire logic         clk_i,
  // Request and pacing.
  input  wire logic         req_i,
  input  wire logic         slow_i,
  // Sample stream.
  output logic              valid_o,
  output logic              last_o,
  output wem_pkg::wem_smp_t data_o
);
  import wem_pkg::*;
  wem_smp_t rec [0:31];
  int       len;
  int       idx;
  logic     wait_low;
  logic     skip;
  logic     was_req;
  logic     was_valid;

  // Start idle with a one-sample record until the bench loads one.
  initial begin
    valid_o = 1'b0;
    last_o = 1'b0;
    data_o = 8'h00;
    idx = 0;
    len = 1;
    wait_low = 1'b0;
    skip = 1'b0;
  end

  // After a last sample the request must drop before the record is sent again,
  // otherwise a lingering request would swallow a third copy.
  always @(posedge clk_i) begin
    was_req = req_i;
    was_valid = valid_o;
    #1;
    if (was_req && was_valid) begin
      wait_low = last_o;
      idx = last_o ? 0 : idx + 1;
    end
    if (!req_i) wait_low = 1'b0;
    skip = slow_i && !skip;
    if (req_i && !wait_low && !skip) begin
      valid_o = 1'b1;
      last_o = (idx == len - 1);
      data_o = rec[idx];
    end else begin
      // Idle data is scrambled so nothing can lean on a stale sample.
      valid_o = 1'b0;
      last_o = 1'b0;
      data_o = ~data_o;
    end
  end
endmodule

// ==== test_wem_measure.sv ====
// Self-checking bench for the measurement engine with a replaying record source.
// Assumes wem_pkg and the engine are compiled first; thresholds are 10/50/90 of 0..100.
`timescale 1ns/1ps
module test_wem_measure;
  import wem_pkg::*;
  logic      clk;
  logic      rst_n;
  logic      start;
  logic      busy;
  logic      done;
  logic      req;
  logic      s_valid;
  logic      s_last;
  logic      slow;
  wem_smp_t  s_data;
  wem_lvl_t  lvl;
  wem_dsel_t dsel_a;
  wem_dsel_t dsel_b;
  wem_res_t  res;
  int        mismatches;
  int        n_compared;
  int        cycles;
  // Two clean pulses with an overshoot sample; edges land on exact sixteenths.
  wem_smp_t  base_rec [0:19] = '{8'h00, 8'h00, 8'h00, 8'h14, 8'h64, 8'h78, 8'h64, 8'h64, 8'h50, 8'h00,
                                 8'h00, 8'h00, 8'h14, 8'h64, 8'h64, 8'h64, 8'h50, 8'h00, 8'h00, 8'h00};

  // A higher minimum span makes every three-sample edge questionable.
  wem_measure #(.MIN_PTS(4)) u_wem_measure (
    .CLK_I        (clk),
    .RESET_N_I    (rst_n),
    .START_I      (start),
    .BUSY_O       (busy),
    .DONE_O       (done),
    .RECORD_REQ_O (req),
    .SMP_VALID_I  (s_valid),
    .SMP_LAST_I   (s_last),
    .SMP_DATA_I   (s_data),
    .LVL_I        (lvl),
    .DSEL_A_I     (dsel_a),
    .DSEL_B_I     (dsel_b),
    .RES_O        (res)
  );

  wem_rec_src u_wem_rec_src (
    .clk_i   (clk),
    .req_i   (req),
    .slow_i  (slow),
    .valid_o (s_valid),
    .last_o  (s_last),
    .data_o  (s_data)
  );

  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // A hung run is cut short well past the few hundred cycles the tests need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Mode 0 plain, 1 with an incomplete glitch, 2 inverted, 3 flat.
  task automatic load(input int mode);
    wem_smp_t v;
    for (int i = 0; i < 20; i++) begin
      v = base_rec[i];
      if (mode == 1 && i == 1) v = 8'h3c;
      if (mode == 2) v = 8'h64 - v;
      if (mode == 3) v = 8'h05;
      u_wem_rec_src.rec[i] = v;
    end
    u_wem_rec_src.len = 20;
  endtask

  // Start a run and wait for its completion pulse; a start on the done cycle chains runs.
  task automatic go;
    int n;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("done", 32'(done), 32'h1);
  endtask

  task automatic test_rise_first;
    load(0);
    dsel_a = '{lvl: 2'h1, fall: 1'b0, num: 8'h01};
    dsel_b = '{lvl: 2'h1, fall: 1'b1, num: 8'h01};
    go();
    chk("rise", 32'(res.rise), 32'h16);
    chk("fall", 32'(res.fall), 32'h16);
    chk("period", 32'(res.period), 32'h90);
    chk("freq", res.freq, 32'h00e3_8e38);
    chk("pwidth", 32'(res.pwidth), 32'h50);
    chk("nwidth", 32'(res.nwidth), 32'h40);
    chk("duty", 32'(res.duty), 32'h37);
    chk("delta", 32'(res.delta), 32'h50);
    chk("vmin", {24'h0, res.vmin}, 32'h00);
    chk("vmax", {24'h0, res.vmax}, 32'h78);
    chk("vpp", 32'(res.vpp), 32'h78);
    chk("vtop", {24'h0, res.vtop}, 32'h64);
    chk("amp", 32'(res.amp), 32'h64);
    chk("over", 32'(res.over), 32'h14);
    chk("pre", 32'(res.pre), 32'h19c);
    chk("avg", {24'h0, res.avg}, 32'h2e);
    chk("rise_q", 32'(res.rise_q), 32'h1);
    chk("vld", 32'(res.vld), 32'h1fff);
  endtask

  task automatic test_glitch_slow;
    load(1);
    slow = 1'b1;
    go();
    slow = 1'b0;
    chk("rise", 32'(res.rise), 32'h16);
    chk("period", 32'(res.period), 32'h90);
    chk("pwidth", 32'(res.pwidth), 32'h50);
    chk("avg", {24'h0, res.avg}, 32'h31);
  endtask

  task automatic test_fall_first;
    load(2);
    dsel_a = '{lvl: 2'h0, fall: 1'b0, num: 8'h02};
    dsel_b = '{lvl: 2'h2, fall: 1'b1, num: 8'h02};
    go();
    chk("fall", 32'(res.fall), 32'h16);
    chk("rise", 32'(res.rise), 32'h16);
    chk("period", 32'(res.period), 32'h90);
    chk("pwidth", 32'(res.pwidth), 32'h40);
    chk("nwidth", 32'(res.nwidth), 32'h50);
    chk("duty", 32'(res.duty), 32'h2c);
    chk("delta", 32'(res.delta), 32'h000f_ffc0);
    chk("vmin", {24'h0, res.vmin}, 32'hec);
    chk("vpp", 32'(res.vpp), 32'h78);
    chk("over", 32'(res.over), 32'h14);
    chk("pre", 32'(res.pre), 32'h19c);
    chk("avg", {24'h0, res.avg}, 32'h36);
    chk("fall_q", 32'(res.fall_q), 32'h1);
  endtask

  task automatic test_flat;
    load(3);
    go();
    chk("vld_time", 32'(res.vld[7:0]), 32'h00);
    chk("vld_avg", 32'(res.vld[11]), 32'h1);
    chk("vmax", {24'h0, res.vmax}, 32'h05);
  endtask

  // Reset, then chain the runs back to back through the done cycle.
  initial begin
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    rst_n = 1'b0;
    start = 1'b0;
    slow = 1'b0;
    lvl = '{lower: 8'h0a, mid: 8'h32, upper: 8'h5a, top: 8'h64, base: 8'h00};
    dsel_a = '0;
    dsel_b = '0;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("busy_rst", 32'(busy), 32'h0);
    test_rise_first();
    test_glitch_slow();
    test_fall_first();
    test_flat();
    tally_and_finish();
  end
endmodule
